// *** sim/arith_link_checker.sv ***
// assertions on the link between sequencer and engine
`default_nettype none
module arith_link_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests
	input wire logic op_valid,
	input wire logic [4:0] op_code,
	input wire logic [4:0] loop_counter,
	input wire logic [15:0] x,
	input wire logic [15:0] y,
	input wire logic acc_sel,
	input wire logic acc_wb,
	input wire logic cfg_we,
	input wire logic [15:0] cfg_wdata,
	// answers
	input wire logic [15:0] cfg_rdata,
	input wire logic div_done,
	input wire logic [39:0] accumulator_a,
	input wire logic [39:0] accumulator_b,
	input wire logic wb_valid
);
	import arith_pkg::*;
	logic is_div;
	logic wb_op;
	assign is_div = op_code >= OP_FRAC_DIV && op_code <= OP_UWORD_DIV;
	assign wb_op = op_code inside {OP_ACC_CLEAR, OP_MAC, OP_MSC, OP_PREFETCH};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_div_done;
		op_valid && is_div && loop_counter == 5'h00 |=> div_done;
	endproperty
	a_div_done: assert property (p_div_done) else $error("no done after last step");
	property p_done_cause;
		div_done |-> $past(op_valid && is_div && loop_counter == 5'h00);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("stray done");
	property p_step;
		op_valid && is_div && loop_counter != 5'h00 |=>
			!op_valid || loop_counter == $past(loop_counter) - 5'h01;
	endproperty
	a_step: assert property (p_step) else $error("loop count skipped");
	property p_range;
		op_valid && is_div |-> loop_counter <= LOOP_FIRST;
	endproperty
	a_range: assert property (p_range) else $error("loop count too large");
	property p_cfg;
		cfg_we |=> cfg_rdata == (($past(cfg_wdata) & CORE_ARITH_CONFIG_WMASK)
			| (CORE_ARITH_CONFIG_RESET & ~CORE_ARITH_CONFIG_WMASK));
	endproperty
	a_cfg: assert property (p_cfg) else $error("config write wrong");
	property p_wb;
		wb_valid |-> $past(op_valid && acc_wb && wb_op);
	endproperty
	a_wb: assert property (p_wb) else $error("stray write-back");
	// negation of the narrow minimum would saturate, so only unsaturated runs
	property p_neg;
		op_valid && op_code == OP_ACC_NEG && !acc_sel && !cfg_rdata[CFG_ACC_A_SAT_BIT]
			|=> accumulator_a == -$past(accumulator_a);
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong");
	property p_mpy;
		op_valid && op_code == OP_MPY && !acc_sel && cfg_rdata[0] && !cfg_rdata[12] |=>
			accumulator_a == 40'($signed($past(x))) * 40'($signed($past(y)))
			&& $stable(accumulator_b);
	endproperty
	a_mpy: assert property (p_mpy) else $error("multiply wrong");
	property p_quiet;
		op_valid && is_div |=> $stable(accumulator_a) && $stable(accumulator_b);
	endproperty
	a_quiet: assert property (p_quiet) else $error("accumulator moved in divide");
endmodule
`default_nettype wire

// *** sim/test_iterative_divide_and_dsp_engine.sv ***
// self-checking bench of the sequencer and engine pair
`default_nettype none
module test_iterative_divide_and_dsp_engine;
	timeunit 1ns;
	timeprecision 1ps;
	import arith_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] config_out;
	logic err;
	logic [31:0] q;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;

	always #5 pclk = ~pclk;

	arith_link i_arith_link (.pclk(pclk), .presetn(presetn));
	arith_engine i_arith_engine (.lk(i_arith_link.dev), .config_out(config_out));
	core_sequencer i_core_sequencer (.lk(i_arith_link.seq), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	arith_link_checker i_arith_link_checker (.pclk(pclk), .presetn(presetn),
		.op_valid(i_arith_link.op_valid), .op_code(i_arith_link.op_code),
		.loop_counter(i_arith_link.loop_counter), .x(i_arith_link.x), .y(i_arith_link.y),
		.acc_sel(i_arith_link.acc_sel), .acc_wb(i_arith_link.acc_wb),
		.cfg_we(i_arith_link.cfg_we), .cfg_wdata(i_arith_link.cfg_wdata),
		.cfg_rdata(i_arith_link.cfg_rdata), .div_done(i_arith_link.div_done),
		.accumulator_a(i_arith_link.accumulator_a),
		.accumulator_b(i_arith_link.accumulator_b), .wb_valid(i_arith_link.wb_valid));

	// ********
	// tasks
	// ********
	task automatic complete_run;
		$display("counts: %0d compares, %0d mismatches", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// no cycle count assumed: the wait ends on pready or on the bench timeout
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	function automatic logic [31:0] ctl(logic [4:0] op, logic sel, logic wb);
		return 32'({wb, sel, op, 1'b1});
	endfunction
	task automatic poll;
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (q[1] === 1'b1) break;
		end
		chk(32'(q[1]), 32'h1);
	endtask
	task automatic div(logic [4:0] op, logic [15:0] xv, logic [15:0] xh, logic [15:0] yv,
		logic [31:0] e);
		wr(REG_OPA, 32'(xv));
		wr(REG_OPB, 32'(xh));
		wr(REG_OPC, 32'(yv));
		wr(REG_CTRL, ctl(op, 1'b0, 1'b0));
		poll();
		rc(REG_RESULT, e);
	endtask
	task automatic dsp(logic [4:0] op, logic sel, logic wb, logic [15:0] xv, logic [15:0] yv,
		logic [39:0] e);
		wr(REG_OPA, 32'(xv));
		wr(REG_OPC, 32'(yv));
		wr(REG_CTRL, ctl(op, sel, wb));
		rc(REG_ACC_LO, e[31:0]);
		rc(REG_ACC_HI, 32'(e[39:32]));
	endtask

	// ceiling well above the several hundred cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	// ********
	// tests
	// ********
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rc(REG_CONFIG, 32'h20);
		chk(32'(config_out), 32'h20);
		wr(REG_CONFIG, 32'hffff);
		rc(REG_CONFIG, 32'h10f7);
		apb(1'b0, 8'h30, 32'h0);
		chk({err, q[30:0]}, 32'h80000000);
		$display("test config done");
		div(OP_FRAC_DIV, 16'h2000, 16'h0, 16'h4000, 32'h4000);
		div(OP_SLONG_DIV, 16'hfc18, 16'hffff, 16'h7, 32'hfffaff72);
		div(OP_ULONG_DIV, 16'h0, 16'h1, 16'h3, 32'h15555);
		div(OP_SWORD_DIV, 16'hfc18, 16'h1234, 16'h7, 32'hfffaff72);
		div(OP_UWORD_DIV, 16'hfc18, 16'h1234, 16'h7, 32'h32403);
		$display("test divide done");
		// operands left from the last divide: fc18 / 7 as a signed word
		wr(REG_CTRL, ctl(OP_SWORD_DIV, 1'b0, 1'b0));
		wr(REG_CTRL, 32'h100);
		repeat (30) @(posedge pclk);
		rc(REG_STATUS, 32'h1);
		wr(REG_CTRL, 32'h0);
		poll();
		rc(REG_RESULT, 32'hfffaff72);
		$display("test pause done");
		wr(REG_CONFIG, 32'h1);
		dsp(OP_MPY, 1'b0, 1'b0, 16'h3, 16'h5, 40'hf);
		dsp(OP_MAC, 1'b0, 1'b0, 16'h2, 16'h4, 40'h17);
		dsp(OP_MSC, 1'b0, 1'b0, 16'h1, 16'h3, 40'h14);
		dsp(OP_SQR_ACC, 1'b0, 1'b0, 16'h2, 16'h0, 40'h18);
		dsp(OP_SQ_DIFF, 1'b0, 1'b0, 16'h7, 16'h4, 40'h9);
		dsp(OP_SQ_DIFF_ACC, 1'b0, 1'b0, 16'h5, 16'h3, 40'hd);
		dsp(OP_MPY_NEG, 1'b0, 1'b0, 16'h3, 16'h5, 40'hfffffffff1);
		dsp(OP_ACC_NEG, 1'b0, 1'b0, 16'h0, 16'h0, 40'hf);
		dsp(OP_MPY, 1'b1, 1'b0, 16'h100, 16'h100, 40'h10000);
		dsp(OP_ACC_ADD, 1'b0, 1'b0, 16'h0, 16'h0, 40'h1000f);
		dsp(OP_ACC_SUB, 1'b0, 1'b0, 16'h0, 16'h0, 40'hf);
		dsp(OP_PREFETCH, 1'b0, 1'b0, 16'h0, 16'h0, 40'hf);
		dsp(OP_ACC_CLEAR, 1'b0, 1'b1, 16'h0, 16'h0, 40'h0);
		rc(REG_WB, 32'h1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(32'(q[2]), 32'h1);
		$display("test engine done");
		wr(REG_CONFIG, 32'h0);
		dsp(OP_MPY, 1'b0, 1'b0, 16'h4000, 16'h4000, 40'h20000000);
		wr(REG_CONFIG, 32'h1001);
		dsp(OP_MPY, 1'b0, 1'b0, 16'hffff, 16'h2, 40'h1fffe);
		wr(REG_CONFIG, 32'h81);
		dsp(OP_MPY, 1'b0, 1'b0, 16'h7fff, 16'h7fff, 40'h3fff0001);
		dsp(OP_ACC_SHIFT, 1'b0, 1'b0, 16'h0, 16'h3e, 40'h7fffffff);
		wr(REG_CONFIG, 32'h91);
		dsp(OP_MPY, 1'b0, 1'b0, 16'h7fff, 16'h7fff, 40'h3fff0001);
		dsp(OP_ACC_SHIFT, 1'b0, 1'b0, 16'h0, 16'h3e, 40'hfffc0004);
		// an exact half: conventional rounds up, convergent keeps the even zero
		wr(REG_CONFIG, 32'h3);
		dsp(OP_MPY, 1'b1, 1'b0, 16'h4000, 16'h2, 40'h8000);
		dsp(OP_ACC_CLEAR, 1'b0, 1'b1, 16'h0, 16'h0, 40'h0);
		rc(REG_WB, 32'h1);
		wr(REG_CONFIG, 32'h1);
		dsp(OP_ACC_CLEAR, 1'b0, 1'b1, 16'h0, 16'h0, 40'h0);
		rc(REG_WB, 32'h0);
		$display("test modes done");
		complete_run();
	end
endmodule
`default_nettype wire

// *** src/arith_engine.sv ***
// device end: iterative divider and multiply-accumulate engine
`default_nettype none
module arith_engine (
	// core link
	arith_link.dev lk,
	// configuration view
	output logic [15:0] config_out
);
	import arith_pkg::*;

	logic [15:0] cfg_r;
	logic [31:0] pair_r;
	logic [15:0] dvsr_r;
	logic qneg_r;
	logic rneg_r;
	logic [15:0] quo_r;
	logic [15:0] rem_r;
	logic done_r;
	logic [39:0] acc_a_r;
	logic [39:0] acc_b_r;
	logic [15:0] wb_r;
	logic wb_valid_r;
	logic is_div;
	logic is_signed;
	logic [31:0] dividend;
	logic dvd_neg;
	logic dvs_neg;
	logic [31:0] dvd_mag;
	logic [15:0] dvs_mag;
	logic [31:0] pair_step;
	logic div_issue;
	logic frac_mode;
	logic sgn_mult;
	logic conv_round;
	logic sat_wide;
	logic sq_op;
	logic wb_op;
	logic acc_wr;
	logic [16:0] diff;
	logic [16:0] xe;
	logic [16:0] ma;
	logic [16:0] mb;
	logic signed [33:0] prod;
	logic [39:0] prod40;
	logic [39:0] acc_cur;
	logic [39:0] acc_oth;
	logic [5:0] neg_amt;
	logic signed [39:0] shr;
	logic [39:0] shifted;
	logic [40:0] sum;
	logic inc;
	logic [23:0] rnd;

	function automatic logic [40:0] ext41(input logic [39:0] v);
		return {v[39], v};
	endfunction

	function automatic logic [39:0] sat40(input logic [40:0] v, input logic en,
			input logic wide);
		logic [39:0] r;
		r = v[39:0];
		if (en && wide && (v[40] != v[39])) begin
			r = v[40] ? SAT_WIDE_MIN : SAT_WIDE_MAX;
		end else if (en && !wide && (v[40:31] != {10{v[40]}})) begin
			r = v[40] ? SAT_NARROW_MIN : SAT_NARROW_MAX;
		end
		return r;
	endfunction

	// ************************************************************
	// configuration register
	// ************************************************************
	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			cfg_r <= CORE_ARITH_CONFIG_RESET;
		end else if (lk.cfg_we) begin
			cfg_r <= (lk.cfg_wdata & CORE_ARITH_CONFIG_WMASK) |
				(cfg_r & ~CORE_ARITH_CONFIG_WMASK);
		end
	end

	assign frac_mode = ~cfg_r[CFG_INT_MODE_BIT];
	assign sgn_mult = ~cfg_r[CFG_SIGN_MODE_BIT];
	assign conv_round = cfg_r[CFG_ROUND_MODE_BIT];
	assign sat_wide = cfg_r[CFG_SAT_MODE_BIT];

	// ************************************************************
	// divider
	// ************************************************************
	always_comb begin
		is_div = 1'b1;
		is_signed = 1'b1;
		dividend = 32'h0;
		case (lk.op_code)
			OP_FRAC_DIV: dividend = {lk.x[15], lk.x, 15'h0};
			OP_SLONG_DIV: dividend = {lk.x_hi, lk.x};
			OP_ULONG_DIV: begin
				dividend = {lk.x_hi, lk.x};
				is_signed = 1'b0;
			end
			OP_SWORD_DIV: dividend = {{16{lk.x[15]}}, lk.x};
			OP_UWORD_DIV: begin
				dividend = {16'h0, lk.x};
				is_signed = 1'b0;
			end
			default: begin
				is_div = 1'b0;
				is_signed = 1'b0;
			end
		endcase
	end

	assign dvd_neg = is_signed & dividend[31];
	assign dvs_neg = is_signed & lk.y[15];
	assign dvd_mag = dvd_neg ? 32'h0 - dividend : dividend;
	assign dvs_mag = dvs_neg ? 16'h0 - lk.y : lk.y;
	assign div_issue = lk.op_valid & is_div;

	div_step u_step (
		.pair(pair_r),
		.divisor(dvsr_r),
		.pair_nxt(pair_step)
	);

	// partial state stays put between issues, so a paused loop resumes
	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			pair_r <= 32'h0;
			dvsr_r <= 16'h0;
			qneg_r <= 1'b0;
			rneg_r <= 1'b0;
		end else if (div_issue) begin
			if (lk.loop_counter == LOOP_FIRST) begin
				pair_r <= dvd_mag;
				dvsr_r <= dvs_mag;
				qneg_r <= dvd_neg ^ dvs_neg;
				rneg_r <= dvd_neg;
			end else if (lk.loop_counter != LOOP_LAST) begin
				pair_r <= pair_step;
			end
		end
	end

	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			quo_r <= 16'h0;
			rem_r <= 16'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= div_issue && (lk.loop_counter == LOOP_LAST);
			if (div_issue && (lk.loop_counter == LOOP_LAST)) begin
				quo_r <= qneg_r ? 16'h0 - pair_r[15:0] : pair_r[15:0];
				rem_r <= rneg_r ? 16'h0 - pair_r[31:16] : pair_r[31:16];
			end
		end
	end

	// ************************************************************
	// multiplier and shifter
	// ************************************************************
	assign acc_cur = lk.acc_sel ? acc_b_r : acc_a_r;
	assign acc_oth = lk.acc_sel ? acc_a_r : acc_b_r;
	assign sq_op = (lk.op_code == OP_SQ_DIFF) || (lk.op_code == OP_SQ_DIFF_ACC);
	// the difference comes from the integer side in the same cycle
	assign diff = {lk.x[15], lk.x} - {lk.y[15], lk.y};
	assign xe = {sgn_mult & lk.x[15], lk.x};
	assign ma = sq_op ? diff : xe;
	assign mb = sq_op ? diff : ((lk.op_code == OP_SQR_ACC) ? xe : {sgn_mult & lk.y[15], lk.y});
	assign prod = $signed(ma) * $signed(mb);
	assign prod40 = frac_mode ? {{5{prod[33]}}, prod, 1'b0} : {{6{prod[33]}}, prod};
	assign neg_amt = 6'h0 - lk.y[5:0];
	assign shr = $signed(acc_cur) >>> lk.y[5:0];
	assign shifted = lk.y[5] ? acc_cur << neg_amt : shr;

	// ************************************************************
	// 41-bit adder and 40-bit accumulators
	// ************************************************************
	always_comb begin
		acc_wr = 1'b1;
		sum = 41'h0;
		case (lk.op_code)
			OP_ACC_CLEAR: sum = 41'h0;
			OP_MPY, OP_SQ_DIFF: sum = ext41(prod40);
			OP_MPY_NEG: sum = 41'h0 - ext41(prod40);
			OP_MAC, OP_SQR_ACC, OP_SQ_DIFF_ACC: sum = ext41(acc_cur) + ext41(prod40);
			OP_MSC: sum = ext41(acc_cur) - ext41(prod40);
			OP_ACC_ADD: sum = ext41(acc_cur) + ext41(acc_oth);
			OP_ACC_SUB: sum = ext41(acc_cur) - ext41(acc_oth);
			OP_ACC_NEG: sum = 41'h0 - ext41(acc_cur);
			OP_ACC_SHIFT: sum = ext41(shifted);
			default: acc_wr = 1'b0;
		endcase
	end

	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			acc_a_r <= 40'h0;
			acc_b_r <= 40'h0;
		end else if (lk.op_valid && acc_wr) begin
			if (lk.acc_sel) begin
				acc_b_r <= sat40(sum, cfg_r[CFG_ACC_B_SAT_BIT], sat_wide);
			end else begin
				acc_a_r <= sat40(sum, cfg_r[CFG_ACC_A_SAT_BIT], sat_wide);
			end
		end
	end

	// ************************************************************
	// write-back of the other accumulator
	// ************************************************************
	assign wb_op = (lk.op_code == OP_ACC_CLEAR) || (lk.op_code == OP_MAC) ||
		(lk.op_code == OP_MSC) || (lk.op_code == OP_PREFETCH);
	// convergent rounding rounds an exact half to even, removing bias
	assign inc = conv_round ? acc_oth[15] :
		(acc_oth[15] & ((acc_oth[14:0] != 15'h0) | acc_oth[16]));
	assign rnd = acc_oth[39:16] + {23'h0, inc};

	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			wb_r <= 16'h0;
			wb_valid_r <= 1'b0;
		end else begin
			wb_valid_r <= lk.op_valid & lk.acc_wb & wb_op;
			if (lk.op_valid && lk.acc_wb && wb_op) begin
				if (cfg_r[CFG_MEM_SAT_BIT] && (rnd[23:15] != {9{rnd[23]}})) begin
					wb_r <= rnd[23] ? SAT_WORD_MIN : SAT_WORD_MAX;
				end else begin
					wb_r <= rnd[15:0];
				end
			end
		end
	end

	assign config_out = cfg_r;
	assign lk.cfg_rdata = cfg_r;
	assign lk.quotient = quo_r;
	assign lk.remainder = rem_r;
	assign lk.div_done = done_r;
	assign lk.accumulator_a = acc_a_r;
	assign lk.accumulator_b = acc_b_r;
	assign lk.wb_valid = wb_valid_r;
	assign lk.wb_data = wb_r;
endmodule
`default_nettype wire

// *** src/arith_link.sv ***
// link between the core sequencer and the arithmetic engine
`default_nettype none
interface arith_link (
	input wire logic pclk,
	input wire logic presetn
);
	logic op_valid;
	logic [4:0] op_code;
	logic [4:0] loop_counter;
	logic [15:0] x;
	logic [15:0] x_hi;
	logic [15:0] y;
	logic acc_sel;
	logic acc_wb;
	logic cfg_we;
	logic [15:0] cfg_wdata;
	logic [15:0] cfg_rdata;
	logic [15:0] quotient;
	logic [15:0] remainder;
	logic div_done;
	logic [39:0] accumulator_a;
	logic [39:0] accumulator_b;
	logic wb_valid;
	logic [15:0] wb_data;

	modport dev (
		input pclk, presetn, op_valid, op_code, loop_counter, x, x_hi, y,
		input acc_sel, acc_wb, cfg_we, cfg_wdata,
		output cfg_rdata, quotient, remainder, div_done,
		output accumulator_a, accumulator_b, wb_valid, wb_data
	);
	modport seq (
		input pclk, presetn,
		output op_valid, op_code, loop_counter, x, x_hi, y,
		output acc_sel, acc_wb, cfg_we, cfg_wdata,
		input cfg_rdata, quotient, remainder, div_done,
		input accumulator_a, accumulator_b, wb_valid, wb_data
	);
endinterface
`default_nettype wire

// *** src/arith_pkg.sv ***
// shared constants of the arithmetic engine and its core sequencer
`default_nettype none
package arith_pkg;
	// ************************************************************
	// engine configuration register
	// ************************************************************
	localparam logic [15:0] CORE_ARITH_CONFIG_OFFSET = 16'h0044;
	localparam logic [15:0] CORE_ARITH_CONFIG_RESET = 16'h0020;
	// writable bits; the rest read back as stored reset value
	localparam logic [15:0] CORE_ARITH_CONFIG_WMASK = 16'h10f7;
	localparam int CFG_SIGN_MODE_BIT = 12;
	localparam int CFG_ACC_A_SAT_BIT = 7;
	localparam int CFG_ACC_B_SAT_BIT = 6;
	localparam int CFG_MEM_SAT_BIT = 5;
	localparam int CFG_SAT_MODE_BIT = 4;
	localparam int CFG_ROUND_MODE_BIT = 1;
	localparam int CFG_INT_MODE_BIT = 0;

	// ************************************************************
	// divide loop
	// ************************************************************
	localparam int DIV_ITERATIONS = 18;
	localparam logic [4:0] LOOP_FIRST = 5'(DIV_ITERATIONS - 1);
	localparam logic [4:0] LOOP_LAST = 5'h00;

	// ************************************************************
	// operation codes
	// ************************************************************
	localparam logic [4:0] OP_FRAC_DIV = 5'h01;
	localparam logic [4:0] OP_SLONG_DIV = 5'h02;
	localparam logic [4:0] OP_ULONG_DIV = 5'h03;
	localparam logic [4:0] OP_SWORD_DIV = 5'h04;
	localparam logic [4:0] OP_UWORD_DIV = 5'h05;
	localparam logic [4:0] OP_ACC_CLEAR = 5'h08;
	localparam logic [4:0] OP_MPY = 5'h09;
	localparam logic [4:0] OP_MPY_NEG = 5'h0a;
	localparam logic [4:0] OP_MAC = 5'h0b;
	localparam logic [4:0] OP_MSC = 5'h0c;
	localparam logic [4:0] OP_SQR_ACC = 5'h0d;
	localparam logic [4:0] OP_SQ_DIFF = 5'h0e;
	localparam logic [4:0] OP_SQ_DIFF_ACC = 5'h0f;
	localparam logic [4:0] OP_PREFETCH = 5'h10;
	localparam logic [4:0] OP_ACC_ADD = 5'h11;
	localparam logic [4:0] OP_ACC_SUB = 5'h12;
	localparam logic [4:0] OP_ACC_NEG = 5'h13;
	localparam logic [4:0] OP_ACC_SHIFT = 5'h14;

	// ************************************************************
	// saturation limits
	// ************************************************************
	localparam logic [39:0] SAT_NARROW_MAX = 40'h007fffffff;
	localparam logic [39:0] SAT_NARROW_MIN = 40'hff80000000;
	localparam logic [39:0] SAT_WIDE_MAX = 40'h7fffffffff;
	localparam logic [39:0] SAT_WIDE_MIN = 40'h8000000000;
	localparam logic [15:0] SAT_WORD_MAX = 16'h7fff;
	localparam logic [15:0] SAT_WORD_MIN = 16'h8000;

	// ************************************************************
	// sequencer register map and fields
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OPA = 8'h04;
	localparam logic [7:0] REG_OPB = 8'h08;
	localparam logic [7:0] REG_OPC = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RESULT = 8'h14;
	localparam logic [7:0] REG_ACC_LO = 8'h18;
	localparam logic [7:0] REG_ACC_HI = 8'h1c;
	localparam logic [7:0] REG_WB = 8'h20;
	localparam logic [7:0] REG_CONFIG = CORE_ARITH_CONFIG_OFFSET[7:0];
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_ACC_SEL_BIT = 6;
	localparam int CTRL_WB_BIT = 7;
	localparam int CTRL_HOLD_BIT = 8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SETUP = 3'b010,
		ST_RUN = 3'b100
	} seq_state_e;
endpackage
`default_nettype wire

// *** src/core_sequencer.sv ***
// far end: core sequencer issuing engine operations, with an APB register port
`default_nettype none
module core_sequencer (
	// engine link
	arith_link.seq lk,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import arith_pkg::*;

	seq_state_e state_r;
	logic [4:0] op_r;
	logic [4:0] count_r;
	logic [4:0] loop_r;
	logic acc_sel_r;
	logic acc_wb_r;
	logic hold_r;
	logic start_r;
	logic done_r;
	logic wb_seen_r;
	logic op_valid_r;
	logic cfg_we_r;
	logic [15:0] opa_r;
	logic [15:0] opb_r;
	logic [15:0] opc_r;
	logic [15:0] cfg_wdata_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic wr;
	logic rd;
	logic busy;
	logic is_div_op;
	logic hit;
	logic [31:0] rdata;

	// a write lands on the edge that completes the transfer, never earlier
	assign wr = psel & penable & pwrite & pready_r;
	assign rd = psel & penable & ~pwrite & ~pready_r;
	// operands and op stay frozen while busy: they are the loop's context
	assign busy = (state_r != ST_IDLE) | start_r | op_valid_r;
	assign is_div_op = (op_r >= OP_FRAC_DIV) && (op_r <= OP_UWORD_DIV);

	// ************************************************************
	// register writes
	// ************************************************************
	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			op_r <= 5'h0;
			acc_sel_r <= 1'b0;
			acc_wb_r <= 1'b0;
			hold_r <= 1'b0;
			start_r <= 1'b0;
			opa_r <= 16'h0;
			opb_r <= 16'h0;
			opc_r <= 16'h0;
			cfg_we_r <= 1'b0;
			cfg_wdata_r <= 16'h0;
		end else begin
			start_r <= 1'b0;
			cfg_we_r <= 1'b0;
			if (wr) begin
				case (paddr)
					REG_CTRL: begin
						hold_r <= pwdata[CTRL_HOLD_BIT];
						if (!busy) begin
							start_r <= pwdata[CTRL_START_BIT];
							op_r <= pwdata[CTRL_OP_LSB +: 5];
							acc_sel_r <= pwdata[CTRL_ACC_SEL_BIT];
							acc_wb_r <= pwdata[CTRL_WB_BIT];
						end
					end
					REG_OPA: if (!busy) opa_r <= pwdata[15:0];
					REG_OPB: if (!busy) opb_r <= pwdata[15:0];
					REG_OPC: if (!busy) opc_r <= pwdata[15:0];
					REG_CONFIG: begin
						cfg_we_r <= 1'b1;
						cfg_wdata_r <= pwdata[15:0];
					end
					default: cfg_we_r <= 1'b0;
				endcase
			end
		end
	end

	// ************************************************************
	// issue sequencer
	// ************************************************************
	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			state_r <= ST_IDLE;
			count_r <= 5'h0;
			loop_r <= 5'h0;
			op_valid_r <= 1'b0;
		end else begin
			op_valid_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start_r && is_div_op) begin
						state_r <= ST_SETUP;
					end else if (start_r) begin
						op_valid_r <= 1'b1;
					end
				end
				ST_SETUP: begin
					count_r <= LOOP_FIRST;
					state_r <= ST_RUN;
				end
				ST_RUN: begin
					if (!hold_r) begin
						op_valid_r <= 1'b1;
						loop_r <= count_r;
						if (count_r == LOOP_LAST) begin
							state_r <= ST_IDLE;
						end else begin
							count_r <= count_r - 5'h01;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			done_r <= 1'b0;
			wb_seen_r <= 1'b0;
		end else begin
			if (lk.div_done) begin
				done_r <= 1'b1;
			end else if (start_r) begin
				done_r <= 1'b0;
			end
			if (lk.wb_valid) begin
				wb_seen_r <= 1'b1;
			end else if (start_r) begin
				wb_seen_r <= 1'b0;
			end
		end
	end

	// ************************************************************
	// register reads and bus answer
	// ************************************************************
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0;
		case (paddr)
			REG_CTRL: rdata = {23'h0, hold_r, acc_wb_r, acc_sel_r, op_r, 1'b0};
			REG_OPA: rdata = {16'h0, opa_r};
			REG_OPB: rdata = {16'h0, opb_r};
			REG_OPC: rdata = {16'h0, opc_r};
			REG_STATUS: rdata = {29'h0, wb_seen_r, done_r, busy};
			REG_RESULT: rdata = {lk.remainder, lk.quotient};
			REG_ACC_LO: rdata = acc_sel_r ? lk.accumulator_b[31:0] : lk.accumulator_a[31:0];
			REG_ACC_HI: rdata = {24'h0, acc_sel_r ? lk.accumulator_b[39:32] :
				lk.accumulator_a[39:32]};
			REG_WB: rdata = {16'h0, lk.wb_data};
			REG_CONFIG: rdata = {16'h0, lk.cfg_rdata};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge lk.pclk or negedge lk.presetn) begin
		if (!lk.presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~hit;
			if (rd) begin
				prdata_r <= rdata;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign lk.op_valid = op_valid_r;
	assign lk.op_code = op_r;
	assign lk.loop_counter = loop_r;
	assign lk.x = opa_r;
	assign lk.x_hi = opb_r;
	assign lk.y = opc_r;
	assign lk.acc_sel = acc_sel_r;
	assign lk.acc_wb = acc_wb_r;
	assign lk.cfg_we = cfg_we_r;
	assign lk.cfg_wdata = cfg_wdata_r;
endmodule
`default_nettype wire

// *** src/div_step.sv ***
// one shift and trial-subtract step of the restoring divider
`default_nettype none
module div_step (
	// partial remainder (high) and quotient (low)
	input wire logic [31:0] pair,
	input wire logic [15:0] divisor,
	// after the step
	output logic [31:0] pair_nxt
);
	logic [32:0] sh;
	logic [16:0] diff;

	assign sh = {pair, 1'b0};
	assign diff = sh[32:16] - {1'b0, divisor};

	always_comb begin
		if (sh[32:16] >= {1'b0, divisor}) begin
			pair_nxt = {diff[15:0], sh[15:1], 1'b1};
		end else begin
			pair_nxt = sh[31:0];
		end
	end
endmodule
`default_nettype wire
